// file: design/audio_tx_unit.v
/*
 audio_tx_unit.v - biphase-mark serial audio transmitter with classic
 wishbone register slave, double-buffered audio and side bits.
 Assumes one 40 MHz clock, synchronous active-high reset, inputs
 synchronous to clk_i, and a single-cycle classic wishbone master.
*/
// The implementer's own choices: the Wishbone register port and the placing of the registers.
// Behaviour
// [RL1] frame is channel A then channel B
// [RL2] double buffering protects current frame
// [RL3] core clock master, external clock slave
// [RL4] reset held unless a pin selected
// [RL5] output pin biphase mark encoded
// [RL6] external clock is 256/384/512 Fs; the code divides for 256 Fs only
// [RL7] clock pin gpio when disabled or master
// [RL8] output pin gpio when not operational
// [RL9] word register fills buffer A then B
// [RL10] buffers load shifter after prior subframe
// [RL11] side bits uploaded at frame start
// [RL12] empty flag when word register, A empty
// [RL13] software writes side bits then audio
// [RL14] Z or X preamble in slots 0-7
// [RL15] 27 data bits in next 54 slots
// [RL16] even parity in last two slots
// [RL17] Y preamble starts channel B subframe
// [RL18] three interrupt sources with own vectors
// [RL19] priority underrun, block, then empty
// [RL20] registers reachable by core and DMA
// [RL21] writing channel B clears empty flag
// [RL22] side bits sent as bits 28-30
// [RL23] shifter sends lsb first
// [RL24] ctrl bits 0,1 enable empty, underrun irq
// [RL25] encoder toggles at cell edge, mid for one
// [RL26] underrun flag, resend previous data
// [RL27] block of 192 frames, Z on first
`timescale 1ns/100ps
`include "audio_tx_map.vh"

module audio_tx_unit (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [4:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // audio pins, each with gpio alternative
   input wire ext_audio_clk_in_i,
   output reg serial_audio_out_o,
   output reg serial_audio_oe_o,
   output reg gpio_clk_pin_alt_o,
   // interrupt requests and dma request
   output reg irq_underrun_o,
   output reg irq_block_o,
   output reg irq_empty_o,
   output reg [1:0] irq_vec_o,
   output reg dma_req_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   reg [`CTL_W-1:0] tx_control_reg_ff; // enables, clock select
   reg [1:0] pin_sel_ff; // 1 = pin belongs to transmitter
   reg [5:0] side_bits_reg_ff; // {b c,u,v, a c,u,v}
   reg [23:0] audio_word_reg_ff; // written word
   reg word_full_ff; // word register holds data
   reg word_is_b_ff; // next write is channel B
   reg [23:0] chan_a_buffer_ff;
   reg a_full_ff;
   reg [23:0] chan_b_buffer_ff;
   reg b_full_ff;
   reg [2:0] chan_b_side_buffer_ff;
   reg [26:0] subframe_shifter_ff;
   reg parity_gen_ff; // running parity
   reg [5:0] slot_ff; // time slot in subframe
   reg in_b_ff; // sending channel B
   reg [7:0] frame_ff; // frame in block
   reg [7:0] pre_ff; // preamble pattern
   reg data_empty_flag_ff;
   reg underrun_flag_ff;
   reg block_start_flag_ff;
   reg line_ff; // line level
   reg [7:0] div_ff; // slot rate divider
   reg ext_d_ff; // external clock sampled
   reg [23:0] last_a_ff; // resent on underrun
   reg [23:0] last_b_ff;
   reg half_ff; // second half of data cell

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   // byte lane merge for 24-bit words
   function [23:0] merge24;
      input [23:0] old;
      input [31:0] wd;
      input [3:0] sl;
      begin
         merge24 = old;
         if (sl[0]) merge24[7:0] = wd[7:0];
         if (sl[1]) merge24[15:8] = wd[15:8];
         if (sl[2]) merge24[23:16] = wd[23:16];
      end
   endfunction

   wire [1:0] clk_sel = tx_control_reg_ff[`CTL_CLK_HI:`CTL_CLK_LO];
   wire unit_rst = rst_i | (pin_sel_ff == 2'h0); // RL4
   wire running = (clk_sel != `CS_OFF) & ~unit_rst;
   // writes land at the edge where the master sees ack high, so a
   // request that is dropped before ack never touches a register
   wire wr = cyc_i & stb_i & we_i & ack_o;
   wire rd_word_b = wr & (adr_i == `ADR_WORD_B);
   wire wr_word = wr & ((adr_i == `ADR_WORD_A) | rd_word_b); // RL20
   // slot enable: core divider in master mode, ext edge in slave mode
   wire ext_rise = ext_audio_clk_in_i & ~ext_d_ff;
   wire slot_tick = running & ((clk_sel == `CS_CORE) ? (div_ff == `CORE_DIV)
                    : (ext_rise & (div_ff[1:0] == `EXT_DIV))); // RL3
   // slot_ff names the first slot of the current pair, so the parity pair
   // at 62 closes the subframe; the reset value 63 also counts as last so
   // the first tick after release opens a fresh channel A subframe
   wire last_slot = (slot_ff >= `PAR_FIRST);
   wire sub_start = slot_tick & last_slot & half_ff;
   wire next_b = ~in_b_ff;
   wire starve = next_b ? ~b_full_ff : ~a_full_ff;
   // ---------------------------------------------------------------
   // wishbone write path and configuration
   // ---------------------------------------------------------------
   // control and pin selection; ack one cycle after request
   always @(posedge clk_i) begin
      if (rst_i) begin
         tx_control_reg_ff <= `CTL_RST;
         pin_sel_ff <= 2'h0;
         ack_o <= 1'b0;
      end else begin
         // ack pulses for one cycle, so one request is never taken twice
         ack_o <= cyc_i & stb_i & ~ack_o;
         if (wr & (adr_i == `ADR_CTRL) & sel_i[0])
            tx_control_reg_ff <= dat_i[`CTL_W-1:0];
         if (wr & (adr_i == `ADR_PINS) & sel_i[0])
            pin_sel_ff <= dat_i[1:0];
      end
   end

   // side bits register is untouched by any transmitter reset
   always @(posedge clk_i) begin
      if (wr & (adr_i == `ADR_SIDE) & sel_i[1])
         side_bits_reg_ff <= dat_i[`SIDE_B_HI:`SIDE_A_LO];
   end

   // read mux, unmapped reads as zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0;
      end else begin
         case (adr_i)
            `ADR_CTRL: dat_o <= {26'h0, tx_control_reg_ff};
            `ADR_STAT: dat_o <= {29'h0, block_start_flag_ff, underrun_flag_ff,
                                 data_empty_flag_ff};
            `ADR_PINS: dat_o <= {30'h0, pin_sel_ff};
            default: dat_o <= 32'h0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // data path: word register, buffers, upload
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (unit_rst) begin
         word_full_ff <= 1'b0;
         word_is_b_ff <= 1'b0;
         a_full_ff <= 1'b0;
         b_full_ff <= 1'b0;
         audio_word_reg_ff <= 24'h0;
         chan_a_buffer_ff <= 24'h0;
         chan_b_buffer_ff <= 24'h0;
         last_a_ff <= 24'h0;
         last_b_ff <= 24'h0;
         chan_b_side_buffer_ff <= 3'h0;
      end else begin
         // write fills word register, alternating A then B
         if (wr_word) begin
            audio_word_reg_ff <= merge24(audio_word_reg_ff, dat_i, sel_i);
            word_full_ff <= 1'b1;
            word_is_b_ff <= rd_word_b | word_is_b_ff;
         end else if (word_full_ff & ~word_is_b_ff & ~a_full_ff) begin
            chan_a_buffer_ff <= audio_word_reg_ff; // RL9
            a_full_ff <= 1'b1;
            word_full_ff <= 1'b0;
            word_is_b_ff <= 1'b1;
         end else if (word_full_ff & word_is_b_ff & ~b_full_ff) begin
            chan_b_buffer_ff <= audio_word_reg_ff; // RL9
            b_full_ff <= 1'b1; // RL2
            word_full_ff <= 1'b0;
            word_is_b_ff <= 1'b0;
         end
         // buffers drain into shifter at subframe start
         // only a buffer that was full is drained: an empty one may be
         // filled by the word register in this same cycle and must keep it
         if (sub_start & next_b & b_full_ff) begin
            b_full_ff <= 1'b0; // RL10
            last_b_ff <= chan_b_buffer_ff;
         end
         if (sub_start & ~next_b & a_full_ff) begin
            a_full_ff <= 1'b0; // RL10
            last_a_ff <= chan_a_buffer_ff;
         end
         if (sub_start & ~next_b)
            chan_b_side_buffer_ff <= side_bits_reg_ff[5:3]; // RL11
      end
   end

   // ---------------------------------------------------------------
   // subframe sequencer, shifter, parity, preamble and encoder
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (unit_rst) begin
         div_ff <= 8'h0;
         ext_d_ff <= 1'b0;
         slot_ff <= `SLOTS_PER_SUB;
         half_ff <= 1'b1;
         in_b_ff <= 1'b1;
         frame_ff <= `FRAMES_LAST;
         subframe_shifter_ff <= 27'h0;
         parity_gen_ff <= 1'b0;
         pre_ff <= 8'h0;
         line_ff <= 1'b0;
      end else begin
         ext_d_ff <= ext_audio_clk_in_i; // RL6
         if (clk_sel == `CS_CORE)
            div_ff <= (div_ff == `CORE_DIV) ? 8'h0 : div_ff + 8'h1;
         else if (ext_rise)
            // two external rising edges per half cell; a stale core count
            // left in the divider folds back to zero within a few edges
            div_ff <= (div_ff[1:0] == `EXT_DIV) ? 8'h0 : div_ff + 8'h1;
         // one tick is one time slot: 8 preamble, 54 data, 2 parity
         if (slot_tick) begin
            half_ff <= ~half_ff;
            if (half_ff) begin
               slot_ff <= last_slot ? 6'h0 : slot_ff + 6'h2;
            end
            if (sub_start) begin
               in_b_ff <= next_b; // RL1
               parity_gen_ff <= 1'b0;
               if (next_b) begin
                  subframe_shifter_ff <= {chan_b_side_buffer_ff,
                     b_full_ff ? chan_b_buffer_ff : last_b_ff}; // RL17
                  pre_ff <= `PRE_Y; // RL17
               end else begin
                  frame_ff <= (frame_ff == `FRAMES_LAST) ? 8'h0 : frame_ff + 8'h1;
                  subframe_shifter_ff <= {side_bits_reg_ff[2:0],
                     a_full_ff ? chan_a_buffer_ff : last_a_ff}; // RL22
                  pre_ff <= (frame_ff == `FRAMES_LAST) ? `PRE_Z : `PRE_X; // RL14
               end
               // this tick is also the second half of the parity cell
               line_ff <= line_ff ^ parity_gen_ff; // RL16
            end else if (slot_ff <= `PRE_LAST) begin
               // preamble: fixed pattern, one bit per time slot
               line_ff <= line_ff ^ pre_ff[7]; // RL25
               pre_ff <= {pre_ff[6:0], 1'b0};
            end else if (slot_ff < `PAR_FIRST) begin // RL15
               // data cell: edge at cell start, mid for one
               if (~half_ff) line_ff <= ~line_ff; // RL5
               else begin
                  line_ff <= line_ff ^ subframe_shifter_ff[0]; // RL25
                  parity_gen_ff <= parity_gen_ff ^ subframe_shifter_ff[0]; // RL16
                  subframe_shifter_ff <= {1'b0, subframe_shifter_ff[26:1]}; // RL23
               end
            end else begin
               // parity cell in last two slots
               if (~half_ff) line_ff <= ~line_ff;
               else line_ff <= line_ff ^ parity_gen_ff; // RL16
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // status flags, set wins over clear
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (unit_rst) begin
         data_empty_flag_ff <= 1'b0;
         underrun_flag_ff <= 1'b0;
         block_start_flag_ff <= 1'b0;
      end else begin
         // empty: word register and buffer A both empty
         if (~word_full_ff & ~a_full_ff & ~wr_word)
            data_empty_flag_ff <= 1'b1; // RL12
         else if (wr_word & word_is_b_ff)
            data_empty_flag_ff <= 1'b0; // RL21
         // a starved subframe in the cycle of a clear keeps the flag set
         if (sub_start & starve)
            underrun_flag_ff <= 1'b1; // RL26
         else if (wr & (adr_i == `ADR_STAT) & sel_i[0] & dat_i[`ST_UNDER])
            underrun_flag_ff <= 1'b0;
         if (sub_start & ~next_b & (frame_ff == `FRAMES_LAST))
            block_start_flag_ff <= 1'b1; // RL27
         else if (sub_start & ~next_b)
            block_start_flag_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs: pins, interrupts, dma
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         serial_audio_out_o <= 1'b0;
         serial_audio_oe_o <= 1'b0;
         gpio_clk_pin_alt_o <= 1'b1;
         irq_underrun_o <= 1'b0;
         irq_block_o <= 1'b0;
         irq_empty_o <= 1'b0;
         irq_vec_o <= 2'h0;
         dma_req_o <= 1'b0;
      end else begin
         serial_audio_out_o <= line_ff;
         serial_audio_oe_o <= running & pin_sel_ff[`PIN_OUT]; // RL8
         // the clock pin is only claimed in slave mode with its pin selected
         gpio_clk_pin_alt_o <= ~(running & (clk_sel == `CS_EXT)
                               & pin_sel_ff[`PIN_CLK]); // RL7
         irq_underrun_o <= underrun_flag_ff & tx_control_reg_ff[`CTL_UNDER_IE]; // RL24
         irq_block_o <= data_empty_flag_ff & block_start_flag_ff
                        & tx_control_reg_ff[`CTL_BLOCK_IE]; // RL18
         irq_empty_o <= data_empty_flag_ff & tx_control_reg_ff[`CTL_EMPTY_IE]; // RL24
         // vector code: 1 underrun, 2 block, 3 empty, 0 none
         if (underrun_flag_ff & tx_control_reg_ff[`CTL_UNDER_IE])
            irq_vec_o <= 2'h1; // RL19
         else if (data_empty_flag_ff & block_start_flag_ff
                  & tx_control_reg_ff[`CTL_BLOCK_IE])
            irq_vec_o <= 2'h2; // RL19
         else if (data_empty_flag_ff & tx_control_reg_ff[`CTL_EMPTY_IE])
            irq_vec_o <= 2'h3; // RL19
         else
            irq_vec_o <= 2'h0;
         // dma follows the empty flag so a channel can refill without the core
         dma_req_o <= data_empty_flag_ff & ~unit_rst; // RL20
      end
   end

endmodule // audio_tx_unit

// file: shared/audio_tx_map.vh
/*
 audio_tx_map.vh - register offsets, field positions, reset values and
 frame constants of the serial audio transmitter.
 Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef AUDIO_TX_MAP_VH
`define AUDIO_TX_MAP_VH

// ---------------------------------------------------------------
// register byte addresses (word index times four)
// ---------------------------------------------------------------
`define ADR_CTRL 5'h00
`define ADR_SIDE 5'h04
`define ADR_WORD_A 5'h08
`define ADR_WORD_B 5'h0c
`define ADR_STAT 5'h10
`define ADR_PINS 5'h14

// ---------------------------------------------------------------
// control field positions
// ---------------------------------------------------------------
`define CTL_EMPTY_IE 0
`define CTL_UNDER_IE 1
`define CTL_BLOCK_IE 2
`define CTL_CLK_LO 3
`define CTL_CLK_HI 4
`define CTL_STBY 5
`define CTL_W 6
`define CTL_RST 6'h00

// clock select codes
`define CS_OFF 2'h0
`define CS_CORE 2'h1
`define CS_EXT 2'h2

// ---------------------------------------------------------------
// status field positions
// ---------------------------------------------------------------
`define ST_EMPTY 0
`define ST_UNDER 1
`define ST_BLOCK 2

// ---------------------------------------------------------------
// side bit positions inside the side bits register
// ---------------------------------------------------------------
`define SIDE_A_LO 10
`define SIDE_A_HI 12
`define SIDE_B_LO 13
`define SIDE_B_HI 15

// pin select bits: bit 0 clock pin, bit 1 output pin
`define PIN_CLK 0
`define PIN_OUT 1

// ---------------------------------------------------------------
// frame timing
// ---------------------------------------------------------------
`define SLOTS_PER_SUB 6'h3f
`define PRE_LAST 6'h07
`define PAR_FIRST 6'h3e
`define FRAMES_LAST 8'hbf
`define CORE_DIV 8'h07
`define EXT_DIV 2'h1
`define PRE_Z 8'he8
`define PRE_Y 8'he4
`define PRE_X 8'he2

`endif

// file: verif/audio_rx_model.sv
/*
 audio_rx_model.sv - far-side receiver: samples the biphase line in the
 middle of each half cell into a level log for the bench to decode.
 Assumes the core-clock slot of eight clk_i cycles per half cell.
*/
`timescale 1ns/100ps
module audio_rx_model (
   // bench clock and watched pins
   input wire clk_i,
   input wire line_i,
   input wire oe_i,
   // free-running external audio clock
   output reg ext_clk_o
);
   reg lv [0:1023]; // half-cell levels in time order
   integer n; // levels logged so far
   reg [7:0] cnt; // cycles since last line edge
   reg last; // line level one cycle ago
   initial begin
      n = 0;
      cnt = 8'h00;
      last = 1'b0;
      ext_clk_o = 1'b0;
   end
   // 10 MHz, 256 times the frame rate of the core-clock mode
   always #50 ext_clk_o = ~ext_clk_o;
   // resync on every edge, log each level mid-slot
   always @(posedge clk_i) begin
      if (!oe_i || line_i != last) cnt <= 8'h01;
      else cnt <= cnt + 8'h01;
      last <= line_i;
      if (oe_i && cnt[2:0] == 3'h4 && n < 1024) begin
         lv[n] <= line_i;
         n <= n + 1;
      end
   end
endmodule // audio_rx_model

// file: verif/audio_tx_unit_assertions.sv
/*
 audio_tx_unit_assertions.sv - port checker for the audio transmitter.
 Assumes bind onto audio_tx_unit, one clock, synchronous reset.
*/
`timescale 1ns/100ps
module audio_tx_unit_checker (
   // clock, reset and bus
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [4:0] adr_i,
   input wire ack_o,
   // line and requests
   input wire serial_audio_out_o,
   input wire serial_audio_oe_o,
   input wire irq_underrun_o,
   input wire irq_block_o,
   input wire irq_empty_o,
   input wire [1:0] irq_vec_o,
   input wire dma_req_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence bus_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence cell_hold;
      $stable(serial_audio_out_o) [*7];
   endsequence
   sequence b_written;
      ack_o && we_i && adr_i == 5'h0c;
   endsequence
   ack_follows_req_a: assert property (bus_req |=> ack_o)
      else $error("ack missing after request");
   ack_one_cycle_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   vec_underrun_a: assert property (irq_underrun_o |-> irq_vec_o == 2'h1)
      else $error("underrun not top vector");
   vec_block_a: assert property (!irq_underrun_o && irq_block_o |-> irq_vec_o == 2'h2)
      else $error("block vector wrong");
   vec_empty_a: assert property (!irq_underrun_o && !irq_block_o && irq_empty_o
      |-> irq_vec_o == 2'h3)
      else $error("empty vector wrong");
   vec_none_a: assert property (!(irq_underrun_o || irq_block_o || irq_empty_o)
      |-> irq_vec_o == 2'h0)
      else $error("vector without request");
   empty_dma_a: assert property (irq_empty_o |-> dma_req_o)
      else $error("empty request without dma request");
   b_clears_a: assert property (b_written |-> ##[1:2] !dma_req_o)
      else $error("channel b write left empty set");
   half_cell_a: assert property (serial_audio_oe_o && $past(serial_audio_oe_o)
      && $changed(serial_audio_out_o) |=> cell_hold)
      else $error("line edge closer than one half cell");
endmodule // audio_tx_unit_checker
bind audio_tx_unit audio_tx_unit_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .ack_o(ack_o),
   .serial_audio_out_o(serial_audio_out_o), .serial_audio_oe_o(serial_audio_oe_o),
   .irq_underrun_o(irq_underrun_o), .irq_block_o(irq_block_o),
   .irq_empty_o(irq_empty_o), .irq_vec_o(irq_vec_o), .dma_req_o(dma_req_o));

// file: verif/audio_tx_unit_bench.sv
/*
 audio_tx_unit_bench.sv - self-checking bench: bus setup, two frames
 decoded from the line, then underrun, masking and clearing.
 Assumes audio_rx_model and the register map header.
*/
`timescale 1ns/100ps
`include "audio_tx_map.vh"
module audio_tx_unit_bench;
   reg clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   reg [4:0] adr = 5'h00;
   reg [3:0] sel = 4'h0;
   reg [31:0] dat = 32'h0, q;
   wire [31:0] dat_o;
   wire [1:0] vec;
   wire ack_o, out_o, oe_o, gpio_o, iu, ib, ie, dma, ext_clk;
   integer n_mismatch = 0, checks = 0, cycles = 0, bperr = 0, p = 1;
   always #12.5 clk_i = ~clk_i;
   audio_tx_unit i_audio_tx_unit (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
      .ack_o(ack_o), .ext_audio_clk_in_i(ext_clk), .serial_audio_out_o(out_o),
      .serial_audio_oe_o(oe_o), .gpio_clk_pin_alt_o(gpio_o), .irq_underrun_o(iu),
      .irq_block_o(ib), .irq_empty_o(ie), .irq_vec_o(vec), .dma_req_o(dma));
   audio_rx_model i_audio_rx_model (.clk_i(clk_i), .line_i(out_o), .oe_i(oe_o),
      .ext_clk_o(ext_clk));
   // verdict and end of run
   task test_done;
      if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_mismatch = n_mismatch + 1;
         test_done;
      end
   end
   task automatic chk(input [31:0] s, input [31:0] e);
      checks = checks + 1;
      if (s !== e) begin
         n_mismatch = n_mismatch + 1;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input [4:0] a, input w, input [31:0] d, output [31:0] r);
      begin
         @(posedge clk_i);
         cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
         @(posedge clk_i);
         // wait as long as it takes: only the hang guard ends a stuck cycle
         while (ack_o !== 1'b1) @(posedge clk_i);
         r = dat_o;
         cyc <= 1'b0; stb <= 1'b0;
      end
   endtask
   function lvl(input integer i);
      lvl = i_audio_rx_model.lv[i];
   endfunction
   // decode one subframe from the level log, counting missing cell edges
   task automatic sub(input integer s, output [7:0] pr, output [26:0] d, output pb);
      integer k, a;
      begin
         // preambles are sent as transition patterns: 1 = level change
         for (k = 0; k < 8; k++) pr[7-k] = lvl(s + k) ^ lvl(s + k - 1);
         for (k = 0; k < 28; k++) begin
            a = s + 8 + 2 * k;
            if (lvl(a) === lvl(a - 1)) bperr = bperr + 1;
            if (k < 27) d[k] = lvl(a) ^ lvl(a + 1);
            else pb = lvl(a) ^ lvl(a + 1);
         end
      end
   endtask
   task automatic wait_log(input integer m);
      integer k;
      for (k = 0; i_audio_rx_model.n < m && k < 20000; k++) @(posedge clk_i);
   endtask
   // reset values, unmapped place, hold while no pin selected
   task automatic t_reset;
      chk(oe_o, 1'b0);
      chk(gpio_o, 1'b1);
      wb(`ADR_CTRL, 1'b0, 32'h0, q);
      chk(q, `CTL_RST);
      wb(5'h1c, 1'b1, 32'hffffffff, q);
      wb(5'h1c, 1'b0, 32'h0, q);
      chk(q, 32'h0);
      wb(`ADR_CTRL, 1'b1, 32'h08, q);
      wb(`ADR_CTRL, 1'b0, 32'h0, q);
      chk(q, 32'h08);
      repeat (40) @(posedge clk_i);
      chk(oe_o, 1'b0);
      wb(`ADR_CTRL, 1'b1, 32'h0, q);
   endtask
   // two frames written and decoded off the line
   task automatic t_frames;
      reg [7:0] pr;
      reg [26:0] d;
      reg pb;
      reg [26:0] ed [0:3];
      reg [7:0] ep [0:3];
      integer k;
      begin
         ed[0] = {3'b101, 24'h5a0f31}; ed[1] = {3'b110, 24'h0f00c7};
         ed[2] = {3'b010, 24'h800001}; ed[3] = {3'b001, 24'hfffffe};
         ep[0] = `PRE_Z; ep[1] = `PRE_Y; ep[2] = `PRE_X; ep[3] = `PRE_Y;
         wb(`ADR_PINS, 1'b1, 32'h3, q);
         wb(`ADR_SIDE, 1'b1, 32'hd400, q);
         wb(`ADR_WORD_A, 1'b1, 32'h5a0f31, q);
         wb(`ADR_WORD_B, 1'b1, 32'h0f00c7, q);
         wb(`ADR_CTRL, 1'b1, 32'h0f, q);
         for (k = 0; dma !== 1'b1 && k < 5000; k++) @(posedge clk_i);
         chk(dma, 1'b1);
         chk(ie, 1'b1);
         chk(ib, 1'b1);
         chk(vec, 2'h2);
         chk(oe_o, 1'b1);
         chk(gpio_o, 1'b1);
         wb(`ADR_SIDE, 1'b1, 32'h2800, q);
         wb(`ADR_WORD_A, 1'b1, 32'h800001, q);
         wb(`ADR_WORD_B, 1'b1, 32'hfffffe, q);
         wait_log(640);
         sub(p, pr, d, pb);
         while (pr !== `PRE_Z && p < 300) begin
            p = p + 1;
            sub(p, pr, d, pb);
         end
         bperr = 0;
         for (k = 0; k < 4; k++) begin
            sub(p + 64 * k, pr, d, pb);
            chk(pr, ep[k]);
            chk(d, ed[k]);
            chk(pb, ^ed[k]);
         end
         chk(bperr, 0);
      end
   endtask
   // no third frame: underrun, resend, mask and clear, then slave mode
   task automatic t_under;
      integer m;
      reg [7:0] pr;
      reg [26:0] d;
      reg pb;
      begin
         wait_log(p + 330);
         sub(p + 256, pr, d, pb);
         chk(pr, `PRE_X);
         chk(d, {3'b010, 24'h800001});
         wb(`ADR_STAT, 1'b0, 32'h0, q);
         chk(q[1], 1'b1);
         chk(iu, 1'b1);
         chk(vec, 2'h1);
         chk(ib, 1'b0);
         wb(`ADR_CTRL, 1'b1, 32'h09, q);
         wb(`ADR_STAT, 1'b0, 32'h0, q);
         chk(iu, 1'b0);
         chk(vec, 2'h3);
         wb(`ADR_STAT, 1'b1, 32'h2, q);
         wb(`ADR_STAT, 1'b0, 32'h0, q);
         chk(q[1], 1'b0);
         // slave mode: one half cell per two external clock rises
         wb(`ADR_CTRL, 1'b1, 32'h00, q);
         wb(`ADR_CTRL, 1'b1, 32'h10, q);
         m = i_audio_rx_model.n;
         repeat (160) @(posedge clk_i);
         chk((i_audio_rx_model.n - m) > 17 && (i_audio_rx_model.n - m) < 23, 1'b1);
         chk(gpio_o, 1'b0);
      end
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_frames;
      t_under;
      test_done;
   end
endmodule // audio_tx_unit_bench
